// *** verilog/ocw_pkg.sv ***
// Package with the register map, field layout and timing of the output channel watchdog.
package ocw_pkg;

	localparam int NUM_CH = 4;
	localparam int ADDR_W = 8;
	localparam int DATA_W = 32;
	localparam int TMO_W  = 16;

	// Register byte addresses.
	localparam logic [ADDR_W-1:0] REG_DOUT       = 8'h00;
	localparam logic [ADDR_W-1:0] REG_DIN        = 8'h04;
	localparam logic [ADDR_W-1:0] REG_CTRL       = 8'h08;
	localparam logic [ADDR_W-1:0] REG_IRQ_STATUS = 8'h0c;
	localparam logic [ADDR_W-1:0] REG_IRQ_ENABLE = 8'h10;
	localparam logic [ADDR_W-1:0] REG_IRQ_CLEAR  = 8'h14;
	localparam logic [ADDR_W-1:0] REG_WD_EXPIRED = 8'h18;
	localparam logic [ADDR_W-1:0] REG_CH_BASE    = 8'h20;
	localparam logic [ADDR_W-1:0] REG_CH_END     = 8'h60;

	// Word index inside a channel block of four words.
	localparam logic [1:0] CH_WORD_TMO    = 2'h0;
	localparam logic [1:0] CH_WORD_CFG    = 2'h1;
	localparam logic [1:0] CH_WORD_TAG_LO = 2'h2;
	localparam logic [1:0] CH_WORD_TAG_HI = 2'h3;

	// Field positions.
	localparam int CTRL_REFRESH_BIT  = 0;
	localparam int CFG_WD_STATE_BIT  = 0;
	localparam int CFG_RANGE_BIT     = 1;

	// Timeout values that switch a channel watchdog off, and the count of one at which it expires.
	localparam logic [TMO_W-1:0] TMO_OFF_LO = 16'h0000;
	localparam logic [TMO_W-1:0] TMO_OFF_HI = 16'hffff;
	localparam logic [TMO_W-1:0] TMO_ONE    = 16'h0001;

	// Reset values.
	localparam logic [TMO_W-1:0]  TMO_RST  = 16'h0000;
	localparam logic [NUM_CH-1:0] DOUT_RST = 4'h0;
	localparam logic [DATA_W-1:0] TAG_RST  = 32'h0000_0000;

	// Timing: figures in ns, cycle counts derived from the 125 MHz clock.
	localparam int CLK_PERIOD_NS  = 8;
	localparam int SECOND_NS      = 1000000000;
	localparam int REFRESH_NS     = 100000000;
	localparam int TICK_CYCLES    = SECOND_NS / CLK_PERIOD_NS;
	localparam int REFRESH_CYCLES = REFRESH_NS / CLK_PERIOD_NS;

	typedef enum logic [1:0] {
		OCW_WD_OFF = 2'b00,
		OCW_WD_RUN = 2'b01,
		OCW_WD_EXP = 2'b11
	} ocw_wd_state_t;

	typedef struct packed {
		logic wd_state;
		logic range_5v;
	} ocw_chan_cfg_t;

	typedef struct packed {
		logic              wr;
		logic              rd;
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] wdata;
	} ocw_bus_req_t;

endpackage

// *** verilog/ocw_prescaler.sv ***
// Free running divider that gives a one-cycle pulse every PERIOD clocks while enabled.
`timescale 1ns/1ps
module ocw_prescaler import ocw_pkg::*; #(
	parameter int unsigned PERIOD = 125000000
) (
	input  wire logic i_ref_clk,
	input  wire logic i_rst,
	input  wire logic i_run,
	output logic      o_tick
);

	logic [31:0] count;

	always_ff @(posedge i_ref_clk) begin
		if (i_rst || !i_run) begin
			count  <= 32'h0000_0000;
			o_tick <= 1'b0;
		end else if (count == 32'(PERIOD - 1)) begin
			count  <= 32'h0000_0000;
			o_tick <= 1'b1;
		end else begin
			count  <= count + 32'h0000_0001;
			o_tick <= 1'b0;
		end
	end

endmodule

// *** verilog/ocw_chan_wdog.sv ***
// Seconds counter of one channel watchdog with reload on access and a one-shot expiry.
`timescale 1ns/1ps
module ocw_chan_wdog import ocw_pkg::*; (
	input  wire logic             i_ref_clk,
	input  wire logic             i_rst,
	input  wire logic             i_tick,
	input  wire logic             i_access,
	input  wire logic [TMO_W-1:0] i_timeout,
	output logic                  o_expire,
	output logic                  o_expired
);

	ocw_wd_state_t    state;
	logic [TMO_W-1:0] count;
	logic             enabled;

	assign enabled = (i_timeout != TMO_OFF_LO) && (i_timeout != TMO_OFF_HI); // see RQ2

	always_ff @(posedge i_ref_clk) begin
		if (i_rst) begin
			state    <= OCW_WD_OFF;
			count    <= TMO_RST;
			o_expire <= 1'b0;
		end else begin
			o_expire <= 1'b0;
			case (state)
				OCW_WD_OFF: begin
					if (enabled) begin
						state <= OCW_WD_RUN;
						count <= i_timeout; // see RQ1
					end
				end
				OCW_WD_RUN: begin
					if (!enabled) begin
						state <= OCW_WD_OFF; // see RQ2
					end else if (i_access) begin
						count <= i_timeout; // see RQ3
					end else if (i_tick) begin
						if (count == TMO_ONE) begin
							state    <= OCW_WD_EXP; // see RQ3
							o_expire <= 1'b1;
						end else begin
							count <= count - TMO_ONE; // see RQ11
						end
					end
				end
				OCW_WD_EXP: begin
					// Expiry fires once; only fresh host activity re-arms the timer.
					if (!enabled) begin
						state <= OCW_WD_OFF;
					end else if (i_access) begin
						state <= OCW_WD_RUN;
						count <= i_timeout;
					end
				end
				default: begin
					state <= OCW_WD_OFF;
				end
			endcase
		end
	end

	assign o_expired = (state == OCW_WD_EXP);

endmodule

// *** verilog/ocw_output_channel_watchdog.sv ***
// Register file, per-channel watchdogs, auto-refresh and interrupt of the output channels.
//
// Overview of operation
// RQ1 - A channel takes a timeout of 1 to 65534 whole seconds and is timed against it.
// RQ2 - A timeout of 0 or 65535 keeps the channel watchdog off so it never expires.
// RQ3 - A channel expires after a full timeout with no read or write; any access restarts it. The tick runs free, so expiry can come up to a second early.
// Only reads and writes of REG_DOUT, REG_DIN or the channel's own block count as an access here; other registers do not restart it.
// RQ4 - On expiry the channel output is driven to its configured safe on or off state.
// RQ5 - With auto-refresh on, every output is rewritten periodically with its programmed value.
// RQ6 - The same periodic rewrite re-enables an output held off by a latched thermal shutdown.
// RQ7 - There are four discrete I/O channels, each with its own timeout and safe state.
// RQ8 - Each analog channel holds a range of plus or minus ten or plus or minus five volts.
// RQ9 - Each channel stores an eight character label that reads back unchanged and steers nothing.
// RQ10 - Writing a one to a digital output always turns it on; the output path has no inversion.
// RQ11 - A prescaled one-second tick counts each enabled channel down; an access reloads it.
`timescale 1ns/1ps
module ocw_output_channel_watchdog import ocw_pkg::*; #(
	parameter int unsigned TICK_PERIOD    = TICK_CYCLES,
	parameter int unsigned REFRESH_PERIOD = REFRESH_CYCLES
) (
	input  wire logic              i_ref_clk,
	input  wire logic              i_rst,
	input  wire logic [ADDR_W-1:0] i_addr,
	input  wire logic [DATA_W-1:0] i_wdata,
	input  wire logic              i_wr,
	input  wire logic              i_rd,
	output logic      [DATA_W-1:0] o_rdata,
	input  wire logic [NUM_CH-1:0] i_din,
	output logic      [NUM_CH-1:0] o_dout,
	output logic                   o_dout_load,
	output logic      [NUM_CH-1:0] o_range_5v,
	output logic                   o_irq
);

	// True when the address lies inside the block of channel ch.
	function automatic logic in_chan(input logic [ADDR_W-1:0] addr, input int ch);
		logic [ADDR_W-1:0] base;
		base = REG_CH_BASE + ADDR_W'(ch * 16);
		in_chan = (addr >= base) && (addr < base + 8'h10);
	endfunction

	// Word index of an address inside a channel block.
	function automatic logic [1:0] chan_word(input logic [ADDR_W-1:0] addr);
		chan_word = addr[3:2];
	endfunction

	// Channel number of an address inside the channel area.
	function automatic logic [1:0] chan_num(input logic [ADDR_W-1:0] addr);
		logic [ADDR_W-1:0] rel;
		rel = addr - REG_CH_BASE;
		chan_num = rel[5:4];
	endfunction

	ocw_bus_req_t  req;
	logic          in_ch_area;

	logic [TMO_W-1:0]  timeout [NUM_CH];
	ocw_chan_cfg_t     cfg     [NUM_CH];
	logic [DATA_W-1:0] tag_mem [2*NUM_CH];

	logic [NUM_CH-1:0] access;
	logic [NUM_CH-1:0] expire;
	logic [NUM_CH-1:0] expired;
	logic [NUM_CH-1:0] irq_status;
	logic [NUM_CH-1:0] irq_enable;
	logic [NUM_CH-1:0] next_irq_status;
	logic              refresh_en;
	logic              sec_tick;
	logic              refresh_tick;
	logic [DATA_W-1:0] next_rdata;

	assign req.wr    = i_wr;
	assign req.rd    = i_rd;
	assign req.addr  = i_addr;
	assign req.wdata = i_wdata;

	assign in_ch_area = (req.addr >= REG_CH_BASE) && (req.addr < REG_CH_END);

	// One-second time base shared by all channel watchdogs.
	ocw_prescaler #(
		.PERIOD (TICK_PERIOD)
	) u_sec_tick (
		.i_ref_clk (i_ref_clk),
		.i_rst     (i_rst),
		.i_run     (1'b1),
		.o_tick    (sec_tick)
	); // see RQ11

	// Refresh time base runs only while auto-refresh is on.
	ocw_prescaler #(
		.PERIOD (REFRESH_PERIOD)
	) u_refresh_tick (
		.i_ref_clk (i_ref_clk),
		.i_rst     (i_rst),
		.i_run     (refresh_en),
		.o_tick    (refresh_tick)
	); // see RQ5

	// A channel counts as accessed by any read or write of the shared data registers
	// or of its own block, so configuration traffic also keeps its watchdog alive.
	genvar g;
	generate
		for (g = 0; g < NUM_CH; g++) begin : g_chan
			assign access[g] = (req.wr || req.rd) &&
				((req.addr == REG_DOUT) || (req.addr == REG_DIN) ||
				in_chan(req.addr, g)); // see RQ3

			ocw_chan_wdog u_wdog (
				.i_ref_clk (i_ref_clk),
				.i_rst     (i_rst),
				.i_tick    (sec_tick),
				.i_access  (access[g]),
				.i_timeout (timeout[g]),
				.o_expire  (expire[g]),
				.o_expired (expired[g])
			); // see RQ7

			always_ff @(posedge i_ref_clk) begin
				if (i_rst) begin
					timeout[g] <= TMO_RST;
				end else if (req.wr && in_chan(req.addr, g) &&
					chan_word(req.addr) == CH_WORD_TMO) begin
					timeout[g] <= req.wdata[TMO_W-1:0]; // see RQ1
				end
			end

			always_ff @(posedge i_ref_clk) begin
				if (i_rst) begin
					cfg[g] <= '0;
				end else if (req.wr && in_chan(req.addr, g) &&
					chan_word(req.addr) == CH_WORD_CFG) begin
					cfg[g].wd_state <= req.wdata[CFG_WD_STATE_BIT]; // see RQ4
					cfg[g].range_5v <= req.wdata[CFG_RANGE_BIT]; // see RQ8
				end
			end

			assign o_range_5v[g] = cfg[g].range_5v; // see RQ8
		end
	endgenerate

	// Labels are plain storage; nothing in the channel logic reads them.
	always_ff @(posedge i_ref_clk) begin
		if (i_rst) begin
			for (int i = 0; i < 2*NUM_CH; i++) begin
				tag_mem[i] <= TAG_RST;
			end
		end else if (req.wr && in_ch_area && chan_word(req.addr) >= CH_WORD_TAG_LO) begin
			tag_mem[{chan_num(req.addr), req.addr[2]}] <= req.wdata; // see RQ9
		end
	end

	always_ff @(posedge i_ref_clk) begin
		if (i_rst) begin
			refresh_en <= 1'b0;
		end else if (req.wr && req.addr == REG_CTRL) begin
			refresh_en <= req.wdata[CTRL_REFRESH_BIT]; // see RQ5
		end
	end

	// Expiry overwrites the programmed value, so a later refresh keeps the safe state
	// instead of bringing back the value the host last wrote before it went silent.
	always_ff @(posedge i_ref_clk) begin
		if (i_rst) begin
			o_dout <= DOUT_RST;
		end else begin
			for (int i = 0; i < NUM_CH; i++) begin
				if (expire[i]) begin
					o_dout[i] <= cfg[i].wd_state; // see RQ4
				end
			end
			if (req.wr && req.addr == REG_DOUT) begin
				o_dout <= req.wdata[NUM_CH-1:0]; // see RQ10
			end
		end
	end

	// The load strobe makes the output driver reapply o_dout; a driver in latched
	// thermal shutdown is released by it, so refresh doubles as a recovery path.
	always_ff @(posedge i_ref_clk) begin
		if (i_rst) begin
			o_dout_load <= 1'b0;
		end else begin
			o_dout_load <= (req.wr && req.addr == REG_DOUT) || (|expire) ||
				(refresh_en && refresh_tick); // see RQ5, see RQ6
		end
	end

	always_comb begin
		next_irq_status = irq_status;
		if (req.wr && req.addr == REG_IRQ_CLEAR) begin
			next_irq_status = next_irq_status & ~req.wdata[NUM_CH-1:0];
		end
		// A new expiry in the clearing cycle is kept.
		next_irq_status = next_irq_status | expire;
	end

	always_ff @(posedge i_ref_clk) begin
		if (i_rst) begin
			irq_status <= '0;
		end else begin
			irq_status <= next_irq_status;
		end
	end

	always_ff @(posedge i_ref_clk) begin
		if (i_rst) begin
			irq_enable <= '0;
		end else if (req.wr && req.addr == REG_IRQ_ENABLE) begin
			irq_enable <= req.wdata[NUM_CH-1:0];
		end
	end

	always_ff @(posedge i_ref_clk) begin
		if (i_rst) begin
			o_irq <= 1'b0;
		end else begin
			o_irq <= |(next_irq_status & irq_enable);
		end
	end

	always_comb begin
		next_rdata = '0;
		if (req.rd) begin
			case (req.addr)
				REG_DOUT:       next_rdata[NUM_CH-1:0] = o_dout;
				REG_DIN:        next_rdata[NUM_CH-1:0] = i_din;
				REG_CTRL:       next_rdata[CTRL_REFRESH_BIT] = refresh_en;
				REG_IRQ_STATUS: next_rdata[NUM_CH-1:0] = irq_status;
				REG_IRQ_ENABLE: next_rdata[NUM_CH-1:0] = irq_enable;
				REG_WD_EXPIRED: next_rdata[NUM_CH-1:0] = expired;
				default: begin
					if (in_ch_area) begin
						case (chan_word(req.addr))
							CH_WORD_TMO: begin
								next_rdata[TMO_W-1:0] = timeout[chan_num(req.addr)];
							end
							CH_WORD_CFG: begin
								next_rdata[CFG_WD_STATE_BIT] =
									cfg[chan_num(req.addr)].wd_state;
								next_rdata[CFG_RANGE_BIT] =
									cfg[chan_num(req.addr)].range_5v;
							end
							default: begin
								next_rdata = tag_mem[{chan_num(req.addr), req.addr[2]}];
							end
						endcase
					end
				end
			endcase
		end
	end

	// Read data stand for the one cycle after the strobe and are zero otherwise.
	always_ff @(posedge i_ref_clk) begin
		if (i_rst) begin
			o_rdata <= '0;
		end else begin
			o_rdata <= next_rdata;
		end
	end

endmodule

// *** tb/ocw_output_channel_watchdog_assertions.sv ***
// Concurrent checks on the ports of the output channel watchdog.
`timescale 1ns/1ps
module ocw_output_channel_watchdog_assertions import ocw_pkg::*; #(
	parameter int unsigned TICK_PERIOD    = TICK_CYCLES,
	parameter int unsigned REFRESH_PERIOD = REFRESH_CYCLES
) (
	input wire logic              i_ref_clk,
	input wire logic              i_rst,
	input wire logic [ADDR_W-1:0] i_addr,
	input wire logic [DATA_W-1:0] i_wdata,
	input wire logic              i_wr,
	input wire logic              i_rd,
	input wire logic [DATA_W-1:0] o_rdata,
	input wire logic [NUM_CH-1:0] i_din,
	input wire logic [NUM_CH-1:0] o_dout,
	input wire logic              o_dout_load,
	input wire logic [NUM_CH-1:0] o_range_5v,
	input wire logic              o_irq
);
	default clocking cb @(posedge i_ref_clk); endclocking
	default disable iff (i_rst);

	a_rdata_idle: assert property (!i_rd |=> o_rdata == '0)
		else $error("read data not zero outside a read");
	a_dout_write: assert property (
		i_wr && i_addr == REG_DOUT |=> o_dout == $past(i_wdata[NUM_CH-1:0]))
		else $error("output write not applied");
	a_din_read: assert property (
		i_rd && i_addr == REG_DIN |=> o_rdata == DATA_W'($past(i_din)))
		else $error("input read wrong");
	a_range_write: assert property (
		i_wr && i_addr == REG_CH_BASE + 8'h04
		|=> o_range_5v[0] == $past(i_wdata[CFG_RANGE_BIT]))
		else $error("range write not applied");
	a_dout_cause: assert property (
		!$stable(o_dout)
		|-> o_dout_load || ($past(i_wr) && $past(i_addr) == REG_DOUT))
		else $error("output changed without cause");
	// An expiry raises the load strobe and the interrupt at the same edge, and a clear
	// acts on the interrupt at once, while an enable write reaches it one edge later.
	a_irq_rise: assert property (
		$rose(o_irq)
		|-> o_dout_load || ($past(i_wr, 2) && $past(i_addr, 2) == REG_IRQ_ENABLE))
		else $error("interrupt rose without cause");
	a_irq_fall: assert property (
		$fell(o_irq)
		|-> ($past(i_wr) && $past(i_addr) == REG_IRQ_CLEAR) ||
			($past(i_wr, 2) && $past(i_addr, 2) == REG_IRQ_ENABLE))
		else $error("interrupt fell without a write");
	a_range_hold: assert property (!$stable(o_range_5v) |-> $past(i_wr))
		else $error("range changed without a write");
endmodule

bind ocw_output_channel_watchdog ocw_output_channel_watchdog_assertions #(
	.TICK_PERIOD(TICK_PERIOD), .REFRESH_PERIOD(REFRESH_PERIOD)
) ocw_output_channel_watchdog_assertions_i (
	.i_ref_clk(i_ref_clk), .i_rst(i_rst), .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr),
	.i_rd(i_rd), .o_rdata(o_rdata), .i_din(i_din), .o_dout(o_dout), .o_dout_load(o_dout_load),
	.o_range_5v(o_range_5v), .o_irq(o_irq)
);

// *** tb/ocw_host_model.sv ***
// Host that reads and writes channel values over the register port.
`timescale 1ns/1ps
module ocw_host_model import ocw_pkg::*; (
	input  wire logic              i_ref_clk,
	input  wire logic [DATA_W-1:0] i_rdata,
	output logic      [ADDR_W-1:0] o_addr,
	output logic      [DATA_W-1:0] o_wdata,
	output logic                   o_wr,
	output logic                   o_rd
);
	initial begin
		o_addr = '0;
		o_wdata = '0;
		o_wr = 1'b0;
		o_rd = 1'b0;
	end
	// A spare edge closes each access so a strobe is never lowered and raised in one step.
	task automatic write_reg(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] v);
		o_addr <= a;
		o_wdata <= v;
		o_wr <= 1'b1;
		@(posedge i_ref_clk);
		o_wr <= 1'b0;
		@(posedge i_ref_clk);
	endtask
	task automatic read_reg(input logic [ADDR_W-1:0] a, output logic [DATA_W-1:0] v);
		o_addr <= a;
		o_rd <= 1'b1;
		@(posedge i_ref_clk);
		o_rd <= 1'b0;
		// Read data stand for this one cycle; take them mid-cycle, clear of both edges.
		@(negedge i_ref_clk);
		v = i_rdata;
		@(posedge i_ref_clk);
	endtask
endmodule

// *** tb/ocw_output_channel_watchdog_test.sv ***
// Self-checking bench of the output channel watchdog.
`timescale 1ns/1ps
module ocw_output_channel_watchdog_test import ocw_pkg::*; ;
	localparam int TICK = 20;
	localparam int REFR = 7;
	localparam logic [DATA_W-1:0] TAG = 32'h6c61_6200;
	logic              clk = 1'b0;
	logic              rst = 1'b1;
	logic [NUM_CH-1:0] din = 4'h5;
	logic [ADDR_W-1:0] addr;
	logic [DATA_W-1:0] wdata;
	logic [DATA_W-1:0] rdata;
	logic              wr;
	logic              rd;
	logic              load;
	logic              irq;
	logic [NUM_CH-1:0] dout;
	logic [NUM_CH-1:0] rng;
	int                n_fail = 0;
	int                total_checks = 0;

	always #4 clk = ~clk;

	ocw_host_model ocw_host_model_i (
		.i_ref_clk(clk), .i_rdata(rdata), .o_addr(addr), .o_wdata(wdata), .o_wr(wr), .o_rd(rd)
	);
	ocw_output_channel_watchdog #(
		.TICK_PERIOD(TICK), .REFRESH_PERIOD(REFR)
	) ocw_output_channel_watchdog_i (
		.i_ref_clk(clk), .i_rst(rst), .i_addr(addr), .i_wdata(wdata), .i_wr(wr), .i_rd(rd),
		.o_rdata(rdata), .i_din(din), .o_dout(dout), .o_dout_load(load), .o_range_5v(rng),
		.o_irq(irq)
	);

	task automatic tally_and_finish();
		$display("checks %0d mismatches %0d", total_checks, n_fail);
		if (n_fail == 0 && total_checks > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	task automatic chk(input logic [DATA_W-1:0] g, input logic [DATA_W-1:0] e);
		total_checks++;
		if (g !== e) begin
			n_fail++;
			$display("unexpected at %0t: got %h expected %h", $time, g, e);
		end
	endtask
	function automatic logic [ADDR_W-1:0] ca(input int n, input logic [1:0] wd);
		return REG_CH_BASE + ADDR_W'(n * 16) + ADDR_W'({wd, 2'b00});
	endfunction
	task automatic w(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] v);
		ocw_host_model_i.write_reg(a, v);
	endtask
	task automatic r(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] e);
		logic [DATA_W-1:0] v;
		ocw_host_model_i.read_reg(a, v);
		chk(v, e);
	endtask
	task automatic wait_dout(input logic [NUM_CH-1:0] e);
		int k;
		k = 0;
		while (dout !== e && k < 2 * TICK) begin
			@(posedge clk);
			k++;
		end
		chk(32'(dout), 32'(e));
	endtask
	// Skipping a few edges first keeps the window clear of the enable phase.
	task automatic count_loads(input int e);
		int c;
		c = 0;
		repeat (8) @(posedge clk);
		repeat (10 * REFR) begin
			@(posedge clk);
			c += 32'(load);
		end
		chk(c, e);
	endtask

	initial begin
		repeat (5000) @(posedge clk);
		n_fail++;
		tally_and_finish();
	end

	initial begin
		repeat (3) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
		r(ca(0, CH_WORD_TMO), '0);
		w(REG_DOUT, 32'ha);
		chk(32'(dout), 32'ha);
		r(REG_DOUT, 32'ha);
		w(REG_DIN, '0);
		r(REG_DIN, 32'h5);
		r(REG_CH_END, '0);
		for (int n = 0; n < NUM_CH; n++) begin
			w(ca(n, CH_WORD_TAG_LO), TAG + n);
			w(ca(n, CH_WORD_TAG_HI), ~TAG - n);
			w(ca(n, CH_WORD_CFG), 32'(n % 2 * 2));
		end
		chk(32'(rng), 32'ha);
		for (int n = 0; n < NUM_CH; n++) begin
			r(ca(n, CH_WORD_TAG_LO), TAG + n);
			r(ca(n, CH_WORD_TAG_HI), ~TAG - n);
			r(ca(n, CH_WORD_CFG), 32'(n % 2 * 2));
		end
		w(ca(0, CH_WORD_CFG), 32'h1);
		w(ca(1, CH_WORD_TMO), 32'hffff);
		w(REG_IRQ_ENABLE, 32'h1);
		w(ca(3, CH_WORD_TMO), 32'h1);
		w(ca(0, CH_WORD_TMO), 32'h3);
		repeat (2 * TICK - 5) @(posedge clk);
		chk(32'(dout), 32'h2);
		r(ca(0, CH_WORD_TAG_LO), TAG);
		repeat (2 * TICK - 5) @(posedge clk);
		chk(32'(dout), 32'h2);
		wait_dout(4'h3);
		repeat (3) @(posedge clk);
		chk(32'(irq), 32'h1);
		r(REG_IRQ_STATUS, 32'h9);
		r(REG_WD_EXPIRED, 32'h9);
		w(REG_IRQ_ENABLE, 32'h0);
		@(posedge clk);
		chk(32'(irq), 32'h0);
		w(REG_IRQ_ENABLE, 32'h8);
		@(posedge clk);
		chk(32'(irq), 32'h1);
		w(REG_IRQ_CLEAR, 32'h8);
		@(posedge clk);
		chk(32'(irq), 32'h0);
		r(REG_IRQ_STATUS, 32'h1);
		w(REG_CTRL, 32'h1);
		count_loads(10);
		chk(32'(dout), 32'h3);
		w(REG_CTRL, 32'h0);
		count_loads(0);
		rst <= 1'b1;
		repeat (3) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
		chk(32'(dout), '0);
		chk(32'(rng), '0);
		r(ca(3, CH_WORD_TMO), '0);
		tally_and_finish();
	end
endmodule
